// File: pkg/secmd_consts.svh
// Constants of the serial EEPROM command engine: codes, bit slots and timing
`ifndef SECMD_CONSTS_SVH
`define SECMD_CONSTS_SVH

// Device select type identifiers, upper nibble of the select byte
`define SECMD_TYPE_ARRAY 4'hA
`define SECMD_TYPE_ID 4'hB

// Field positions
`define SECMD_RW_BIT 0
`define SECMD_LOCK_DATA_BIT 1
`define SECMD_ID_SEL_BIT 10
`define SECMD_ARRAY_AW 12

// Bit slot counter values within one nine-slot byte frame
`define SECMD_LAST_BIT 4'h7
`define SECMD_ACK_SLOT 4'h8
`define SECMD_SLOT_DONE 4'h9

// Page and correction group geometry
`define SECMD_PAGE_BYTES 32
`define SECMD_GROUP_BITS 32
`define SECMD_CHECK_BITS 7
`define SECMD_CHECK_TAG 2'h3
`define SECMD_ERASED_GROUP 32'hFFFFFFFF

// Internal write cycle time and clock period
`define SECMD_TW_MS 5
`define SECMD_NS_PER_MS 1000000
`define SECMD_CLK_NS 10

`endif

// File: pkg/secmd_pkg.sv
// Types shared by the serial EEPROM command engine modules
package secmd_pkg;

   // Command sequencer states, Gray coded along the usual path
   typedef enum logic [2:0] {
      SECMD_IDLE = 3'h0,
      SECMD_DEVSEL = 3'h1,
      SECMD_ADDRH = 3'h3,
      SECMD_ADDRL = 3'h2,
      SECMD_WDATA = 3'h6,
      SECMD_RSEL = 3'h7,
      SECMD_RDATA = 3'h5,
      SECMD_BUSY = 3'h4
   } secmd_state_e;

   // Synchronised pin levels and bus events, all on the mclk domain
   typedef struct packed {
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
      logic sda;
      logic wp;
      logic [2:0] cs;
   } secmd_bus_s;

endpackage : secmd_pkg

// File: hw/secmd_sync.sv
// Pin synchroniser and start, stop and clock edge detector
module secmd_sync (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Raw pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic wp_in,
   input wire logic [2:0] cs_in,
   // Events and levels
   output secmd_pkg::secmd_bus_s bus
);

   logic [5:0] meta_reg;
   logic [5:0] sync_reg;
   logic scl_d_reg;
   logic sda_d_reg;

   // Two flops per pin; only sync_reg is read downstream
   always_ff @(posedge mclk) begin
      if (reset) begin
         meta_reg <= 6'h03;
         sync_reg <= 6'h03;
      end else begin
         meta_reg <= {cs_in, wp_in, sda_in, scl_in};
         sync_reg <= meta_reg;
      end
   end

   // Delayed copies for edge detection
   always_ff @(posedge mclk) begin
      if (reset) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= sync_reg[0];
         sda_d_reg <= sync_reg[1];
      end
   end

   // Start and stop need SCL high in both samples
   assign bus.scl_rise = sync_reg[0] & ~scl_d_reg;
   assign bus.scl_fall = ~sync_reg[0] & scl_d_reg;
   assign bus.start = sync_reg[0] & scl_d_reg & sda_d_reg & ~sync_reg[1];
   assign bus.stop = sync_reg[0] & scl_d_reg & ~sda_d_reg & sync_reg[1];
   assign bus.sda = sync_reg[1];
   assign bus.wp = sync_reg[2];
   assign bus.cs = sync_reg[5:3];

endmodule : secmd_sync

// File: hw/secmd_mem.sv
// Nonvolatile array and identification page stored in ECC protected groups
`include "secmd_consts.svh"
module secmd_mem (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Read port, combinational
   input wire logic rd_id,
   input wire logic [11:0] rd_addr,
   output logic [7:0] rd_data,
   // Byte write port
   input wire logic wr_en,
   input wire logic wr_id,
   input wire logic [11:0] wr_addr,
   input wire logic [7:0] wr_data
);

   localparam int DW = `SECMD_GROUP_BITS;
   localparam int CW = `SECMD_CHECK_BITS;

   logic [DW+CW-1:0] cell_mem [0:2047];
   logic [2047:0] written_reg;
   logic [10:0] rd_idx;
   logic [10:0] wr_idx;
   logic [DW-1:0] rd_word;
   logic [DW-1:0] old_word;
   logic [DW-1:0] new_word;

   // Check code: each data bit owns a syndrome that is never a power of two
   function automatic logic [CW-1:0] secmd_enc(input logic [DW-1:0] d);
      logic [CW-1:0] c;
      c = '0;
      for (int j = 0; j < DW; j++) begin
         if (d[j]) begin
            c = c ^ {`SECMD_CHECK_TAG, 5'(j)};
         end
      end
      return c;
   endfunction : secmd_enc

   // Correct one flipped data bit; a flipped check bit leaves data alone
   function automatic logic [DW-1:0] secmd_fix(input logic [DW+CW-1:0] w);
      logic [CW-1:0] syn;
      logic [DW-1:0] d;
      d = w[DW-1:0];
      syn = w[DW+CW-1:DW] ^ secmd_enc(w[DW-1:0]);
      for (int j = 0; j < DW; j++) begin
         if (syn == {`SECMD_CHECK_TAG, 5'(j)}) begin
            d[j] = ~d[j];
         end
      end
      return d;
   endfunction : secmd_fix

   // Group index; the identification page sits above the array groups
   function automatic logic [10:0] secmd_gidx(input logic id, input logic [11:0] a);
      return id ? {1'b1, 7'h00, a[4:2]} : {1'b0, a[11:2]};
   endfunction : secmd_gidx

   // Never written groups read as erased, so no array reset is needed
   always_comb begin
      rd_idx = secmd_gidx(rd_id, rd_addr);
      wr_idx = secmd_gidx(wr_id, wr_addr);
      rd_word = written_reg[rd_idx] ? secmd_fix(cell_mem[rd_idx]) : `SECMD_ERASED_GROUP;
      old_word = written_reg[wr_idx] ? secmd_fix(cell_mem[wr_idx]) : `SECMD_ERASED_GROUP;
      new_word = old_word;
      new_word[{wr_addr[1:0], 3'h0} +: 8] = wr_data;
      rd_data = rd_word[{rd_addr[1:0], 3'h0} +: 8];
   end

   // Whole group rewritten with fresh check bits on every byte write
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         cell_mem[wr_idx] <= {secmd_enc(new_word), new_word};
      end
   end

   // Erased-state tracking
   always_ff @(posedge mclk) begin
      if (reset) begin
         written_reg <= '0;
      end else if (wr_en) begin
         written_reg[wr_idx] <= 1'b1;
      end
   end

endmodule : secmd_mem

// File: hw/secmd_engine.sv
// Serial EEPROM command engine: select, address, write, read and lock decoding
`include "secmd_consts.svh"
module secmd_engine #(
   parameter int WRITE_CYCLES = `SECMD_TW_MS * `SECMD_NS_PER_MS / `SECMD_CLK_NS,
   parameter int PAGE_BYTES = `SECMD_PAGE_BYTES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Two-wire bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Strap and protect pins
   input wire logic write_protect_input,
   input wire logic chip_select_bit_two,
   input wire logic chip_select_bit_one,
   input wire logic chip_select_bit_zero,
   // Status
   output logic write_busy,
   output logic id_page_locked
);

   localparam int PW = $clog2(PAGE_BYTES);
   localparam int TW = $clog2(WRITE_CYCLES + 1);

   // Refuse page sizes the address logic cannot serve and write cycles too short to drain a page
   if (PAGE_BYTES != `SECMD_PAGE_BYTES) begin : g_bad_page
      $error("page size must stay at the documented value");
   end
   if (WRITE_CYCLES <= PAGE_BYTES) begin : g_bad_tw
      $error("write cycle too short to commit a page");
   end

   secmd_pkg::secmd_bus_s bus;
   secmd_pkg::secmd_state_e state_reg;
   secmd_pkg::secmd_state_e dec_state;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] byte_in;
   logic [7:0] tx_reg;
   logic [7:0] rd_data;
   logic [15:0] addr_reg;
   logic [7:0] page_buf [0:PAGE_BYTES-1];
   logic [PAGE_BYTES-1:0] mask_reg;
   logic [PW-1:0] last_reg;
   logic [TW-1:0] busy_cnt_reg;
   logic ack_reg;
   logic oe_reg;
   logic acked10_reg;
   logic id_reg;
   logic lock_mode_reg;
   logic any_byte_reg;
   logic lock_pend_reg;
   logic lock_reg;
   logic dec_ack;
   logic dec_store;
   logic dec_lock;
   logic rx_state;
   logic byte_done;
   logic ack_rise;
   logic commit_ok;
   logic busy_done;
   logic wr_en;
   logic [PW-1:0] busy_idx;

   // Pin synchroniser and edge finder
   secmd_sync u_sync (
      .mclk(mclk),
      .reset(reset),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .wp_in(write_protect_input),
      .cs_in({chip_select_bit_two, chip_select_bit_one, chip_select_bit_zero}),
      .bus(bus)
   );

   // Protected storage
   secmd_mem u_mem (
      .mclk(mclk),
      .reset(reset),
      .rd_id(id_reg),
      .rd_addr(addr_reg[`SECMD_ARRAY_AW-1:0]),
      .rd_data(rd_data),
      .wr_en(wr_en),
      .wr_id(id_reg),
      .wr_addr({addr_reg[`SECMD_ARRAY_AW-1:PW], busy_idx}),
      .wr_data(page_buf[busy_idx])
   );

   // Slot qualifiers
   assign rx_state = (state_reg == secmd_pkg::SECMD_DEVSEL) ||
                     (state_reg == secmd_pkg::SECMD_ADDRH) ||
                     (state_reg == secmd_pkg::SECMD_ADDRL) ||
                     (state_reg == secmd_pkg::SECMD_WDATA);
   assign byte_in = {shift_reg[6:0], bus.sda};
   assign byte_done = bus.scl_rise && rx_state && (bit_cnt_reg == `SECMD_LAST_BIT);
   assign ack_rise = bus.scl_rise && (bit_cnt_reg == `SECMD_ACK_SLOT);

   // Commit needs at least one accepted byte, so a refused write starts nothing
   assign commit_ok = (state_reg == secmd_pkg::SECMD_WDATA) && acked10_reg &&
                      ((mask_reg != '0) || lock_pend_reg);
   assign busy_done = (state_reg == secmd_pkg::SECMD_BUSY) &&
                      (busy_cnt_reg == TW'(WRITE_CYCLES - 1));
   assign busy_idx = busy_cnt_reg[PW-1:0];
   assign wr_en = (state_reg == secmd_pkg::SECMD_BUSY) &&
                  (busy_cnt_reg < TW'(PAGE_BYTES)) && mask_reg[busy_idx];

   // Decision taken when a received byte completes
   always_comb begin
      dec_ack = 1'b0;
      dec_store = 1'b0;
      dec_lock = 1'b0;
      dec_state = state_reg;
      unique case (state_reg)
         secmd_pkg::SECMD_DEVSEL: begin
            if (((byte_in[7:4] == `SECMD_TYPE_ARRAY) || (byte_in[7:4] == `SECMD_TYPE_ID)) &&
                (byte_in[3:1] == bus.cs)) begin
               dec_ack = 1'b1;
               dec_state = byte_in[`SECMD_RW_BIT] ? secmd_pkg::SECMD_RSEL :
                                                    secmd_pkg::SECMD_ADDRH;
            end else begin
               dec_state = secmd_pkg::SECMD_IDLE;
            end
         end
         secmd_pkg::SECMD_ADDRH: begin
            dec_ack = 1'b1;
            dec_state = secmd_pkg::SECMD_ADDRL;
         end
         secmd_pkg::SECMD_ADDRL: begin
            dec_ack = 1'b1;
            dec_state = secmd_pkg::SECMD_WDATA;
         end
         secmd_pkg::SECMD_WDATA: begin
            if (lock_mode_reg) begin
               // Only the first byte of the lock form counts
               dec_lock = !any_byte_reg && !bus.wp && !lock_reg &&
                          byte_in[`SECMD_LOCK_DATA_BIT];
               dec_ack = dec_lock;
            end else begin
               dec_store = !bus.wp && !(id_reg && lock_reg);
               dec_ack = dec_store;
            end
         end
         secmd_pkg::SECMD_IDLE, secmd_pkg::SECMD_RSEL,
         secmd_pkg::SECMD_RDATA, secmd_pkg::SECMD_BUSY: begin
         end
      endcase
   end

   // Bus sequencing: state, slot counter and the open-drain enable
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg <= secmd_pkg::SECMD_IDLE;
         bit_cnt_reg <= 4'h0;
         ack_reg <= 1'b0;
         oe_reg <= 1'b0;
         acked10_reg <= 1'b0;
      end else if (state_reg == secmd_pkg::SECMD_BUSY) begin
         oe_reg <= 1'b0;
         acked10_reg <= 1'b0;
         if (busy_done) begin
            state_reg <= secmd_pkg::SECMD_IDLE;
         end
      end else if (bus.start) begin
         state_reg <= secmd_pkg::SECMD_DEVSEL;
         bit_cnt_reg <= 4'h0;
         ack_reg <= 1'b0;
         oe_reg <= 1'b0;
         acked10_reg <= 1'b0;
      end else if (bus.stop) begin
         state_reg <= commit_ok ? secmd_pkg::SECMD_BUSY : secmd_pkg::SECMD_IDLE;
         bit_cnt_reg <= 4'h0;
         ack_reg <= 1'b0;
         oe_reg <= 1'b0;
         acked10_reg <= 1'b0;
      end else if (state_reg != secmd_pkg::SECMD_IDLE) begin
         if (bus.scl_rise) begin
            if (bit_cnt_reg < `SECMD_SLOT_DONE) begin
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (byte_done) begin
               ack_reg <= dec_ack;
               state_reg <= dec_state;
            end
            if (ack_rise && (state_reg == secmd_pkg::SECMD_RDATA) && bus.sda) begin
               state_reg <= secmd_pkg::SECMD_IDLE;
            end
         end
         if (bus.scl_fall) begin
            // The tenth slot lasts from the ack's trailing fall to the next fall
            acked10_reg <= (bit_cnt_reg == `SECMD_SLOT_DONE) &&
                           (state_reg == secmd_pkg::SECMD_WDATA) && ack_reg;
            if (bit_cnt_reg == `SECMD_ACK_SLOT) begin
               oe_reg <= (state_reg != secmd_pkg::SECMD_RDATA) && ack_reg;
            end else if (bit_cnt_reg == `SECMD_SLOT_DONE) begin
               bit_cnt_reg <= 4'h0;
               ack_reg <= 1'b0;
               if ((state_reg == secmd_pkg::SECMD_RSEL) ||
                   (state_reg == secmd_pkg::SECMD_RDATA)) begin
                  oe_reg <= ~rd_data[7];
                  state_reg <= secmd_pkg::SECMD_RDATA;
               end else begin
                  oe_reg <= 1'b0;
               end
            end else if (state_reg == secmd_pkg::SECMD_RDATA) begin
               oe_reg <= ~tx_reg[3'(`SECMD_LAST_BIT - bit_cnt_reg)];
            end
         end
      end
   end

   // Receive shifter and transmit byte
   always_ff @(posedge mclk) begin
      if (reset) begin
         shift_reg <= 8'h00;
         tx_reg <= 8'hFF;
      end else begin
         if (bus.scl_rise && rx_state && (bit_cnt_reg < `SECMD_ACK_SLOT)) begin
            shift_reg <= byte_in;
         end
         if (bus.scl_fall && (bit_cnt_reg == `SECMD_SLOT_DONE) && !bus.start &&
             ((state_reg == secmd_pkg::SECMD_RSEL) || (state_reg == secmd_pkg::SECMD_RDATA))) begin
            tx_reg <= rd_data;
         end
      end
   end

   // Address counter
   always_ff @(posedge mclk) begin
      if (reset) begin
         addr_reg <= 16'h0000;
      end else if (state_reg == secmd_pkg::SECMD_BUSY) begin
         if (busy_done && (mask_reg != '0)) begin
            addr_reg[PW-1:0] <= last_reg + PW'(1);
         end
      end else if (!bus.start && !bus.stop) begin
         if (byte_done && (state_reg == secmd_pkg::SECMD_ADDRH)) begin
            addr_reg[15:8] <= byte_in;
         end
         if (byte_done && (state_reg == secmd_pkg::SECMD_ADDRL)) begin
            addr_reg[7:0] <= byte_in;
         end
         if (byte_done && dec_store) begin
            addr_reg[PW-1:0] <= addr_reg[PW-1:0] + PW'(1);
         end
         if (ack_rise && (state_reg == secmd_pkg::SECMD_RDATA)) begin
            // Page reads stay inside the page; array reads wrap to 00h
            if (id_reg) begin
               addr_reg[PW-1:0] <= addr_reg[PW-1:0] + PW'(1);
            end else begin
               addr_reg[`SECMD_ARRAY_AW-1:0] <=
                  addr_reg[`SECMD_ARRAY_AW-1:0] + `SECMD_ARRAY_AW'(1);
            end
         end
      end
   end

   // Page buffer data; only the mask decides what is committed
   always_ff @(posedge mclk) begin
      if (state_reg != secmd_pkg::SECMD_BUSY && byte_done && dec_store) begin
         page_buf[addr_reg[PW-1:0]] <= byte_in;
      end
   end

   // Page buffer mask and last modified byte
   always_ff @(posedge mclk) begin
      if (reset) begin
         mask_reg <= '0;
         last_reg <= '0;
      end else if (state_reg == secmd_pkg::SECMD_BUSY) begin
         if (busy_done) begin
            mask_reg <= '0;
         end
      end else if (bus.start || (byte_done && (state_reg == secmd_pkg::SECMD_ADDRL))) begin
         mask_reg <= '0;
      end else if (!bus.stop && byte_done && dec_store) begin
         mask_reg[addr_reg[PW-1:0]] <= 1'b1;
         last_reg <= addr_reg[PW-1:0];
      end
   end

   // Command mode flags
   always_ff @(posedge mclk) begin
      if (reset) begin
         id_reg <= 1'b0;
         lock_mode_reg <= 1'b0;
         any_byte_reg <= 1'b0;
         lock_pend_reg <= 1'b0;
      end else if (state_reg == secmd_pkg::SECMD_BUSY) begin
         if (busy_done) begin
            lock_pend_reg <= 1'b0;
         end
      end else if (bus.start) begin
         lock_mode_reg <= 1'b0;
         any_byte_reg <= 1'b0;
         lock_pend_reg <= 1'b0;
      end else if (!bus.stop && byte_done) begin
         if (state_reg == secmd_pkg::SECMD_DEVSEL) begin
            id_reg <= (byte_in[7:4] == `SECMD_TYPE_ID);
         end
         if (state_reg == secmd_pkg::SECMD_ADDRL) begin
            lock_mode_reg <= id_reg && addr_reg[`SECMD_ID_SEL_BIT];
         end
         if (state_reg == secmd_pkg::SECMD_WDATA) begin
            any_byte_reg <= 1'b1;
            lock_pend_reg <= lock_pend_reg | dec_lock;
         end
      end
   end

   // Write cycle timer; bytes drain to the array in its first cycles
   always_ff @(posedge mclk) begin
      if (reset || (state_reg != secmd_pkg::SECMD_BUSY)) begin
         busy_cnt_reg <= '0;
      end else begin
         busy_cnt_reg <= busy_cnt_reg + TW'(1);
      end
   end

   // Lock is one-way until power-on reset
   always_ff @(posedge mclk) begin
      if (reset) begin
         lock_reg <= 1'b0;
      end else if (busy_done && lock_pend_reg) begin
         lock_reg <= 1'b1;
      end
   end

   // Open drain: the pad only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = oe_reg;
   assign write_busy = (state_reg == secmd_pkg::SECMD_BUSY);
   assign id_page_locked = lock_reg;

endmodule : secmd_engine

// File: verification/secmd_checker.sv
// Port checker for the serial EEPROM command engine
module secmd_checker #(
   parameter int WRITE_CYCLES = 64
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Bus, straps and status
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic write_protect_input,
   input wire logic chip_select_bit_two,
   input wire logic chip_select_bit_one,
   input wire logic chip_select_bit_zero,
   input wire logic write_busy,
   input wire logic id_page_locked
);
   timeunit 1ns;
   timeprecision 1ps;
   int busy_cnt_reg;
   int oe_cnt_reg;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   // Length of the current busy and drive stretches
   always_ff @(posedge mclk) begin
      busy_cnt_reg <= (reset || !write_busy) ? 0 : busy_cnt_reg + 1;
      oe_cnt_reg <= (reset || !sda_oe) ? 0 : oe_cnt_reg + 1;
   end
   a_open_drain: assert property (sda_out == 1'b0)
      else $error("data value not held low");
   a_busy_quiet: assert property (write_busy |-> !sda_oe)
      else $error("data line driven during write cycle");
   a_busy_length: assert property ($fell(write_busy) |->
      busy_cnt_reg >= WRITE_CYCLES - 1 && busy_cnt_reg <= WRITE_CYCLES + 1)
      else $error("write cycle length wrong");
   a_busy_after_stop: assert property ($rose(write_busy) |-> scl_in && sda_in)
      else $error("write cycle not started by stop");
   a_wp_no_write: assert property ($rose(write_busy) |-> !write_protect_input)
      else $error("write cycle under write protect");
   a_lock_sticky: assert property (id_page_locked |=> id_page_locked)
      else $error("page lock lost");
   a_lock_by_cycle: assert property ($rose(id_page_locked) |->
      write_busy || $past(write_busy))
      else $error("lock set outside write cycle");
   a_drive_bounded: assert property (oe_cnt_reg <= 72)
      else $error("data line held too long");
   a_reset_quiet: assert property (disable iff (1'b0)
      reset |=> !write_busy && !sda_oe && !id_page_locked)
      else $error("outputs active after reset");
   cover property ($rose(write_busy));
   cover property ($rose(id_page_locked));
   cover property ($rose(sda_oe) && write_protect_input);
endmodule : secmd_checker

bind secmd_engine secmd_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.mclk(mclk),
   .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .write_protect_input(write_protect_input), .chip_select_bit_two(chip_select_bit_two),
   .chip_select_bit_one(chip_select_bit_one), .chip_select_bit_zero(chip_select_bit_zero),
   .write_busy(write_busy), .id_page_locked(id_page_locked));

// File: verification/secmd_master.sv
// Two-wire bus master model: drives the clock and pulls data low
module secmd_master (
   // Clock
   input wire logic mclk,
   // Bus lines
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus: clock stands high, data left to the pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Data moves only while the clock is low; sampled late in the high half
   task automatic bit_io(input logic d, output logic q);
      @(posedge mclk) scl <= 1'b0;
      repeat (2) @(posedge mclk);
      sda_low <= !d;
      repeat (2) @(posedge mclk);
      scl <= 1'b1;
      repeat (3) @(posedge mclk); // Four low, four high: an 80 ns bus clock
      q = sda;
   endtask : bit_io
   // Start or repeated start: data falls with the clock high
   task automatic start();
      @(posedge mclk) scl <= 1'b0;
      repeat (2) @(posedge mclk);
      sda_low <= 1'b0;
      repeat (2) @(posedge mclk);
      scl <= 1'b1;
      repeat (2) @(posedge mclk);
      sda_low <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask : start
   // Stop in the slot after the last acknowledge; clock then stands high
   task automatic stop();
      @(posedge mclk) scl <= 1'b0;
      repeat (2) @(posedge mclk);
      sda_low <= 1'b1;
      repeat (2) @(posedge mclk);
      scl <= 1'b1;
      repeat (2) @(posedge mclk);
      sda_low <= 1'b0;
      repeat (6) @(posedge mclk);
   endtask : stop
   // Byte out, most significant bit first, then the device's answer
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic q;
      for (int i = 7; i >= 0; i--) bit_io(b[i], q);
      bit_io(1'b1, q);
      ack = !q;
   endtask : wbyte
   // Byte in, then our own acknowledge or refusal
   task automatic rbyte(input logic mack, output logic [7:0] b);
      logic q;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, q);
         b[i] = q;
      end
      bit_io(!mack, q);
   endtask : rbyte
endmodule : secmd_master

// File: verification/secmd_engine_tb.sv
// Self-checking bench for the serial EEPROM command engine
module secmd_engine_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic wp = 1'b0;
   logic scl, m_low, sda_oe, sda_out, busy, locked, ok;
   logic [2:0] cs = 3'h5;
   logic [7:0] rb;
   int fail_count = 0;
   int compares = 0;
   // Pulled-up data line, low when either side pulls
   wire sda = !(sda_oe || m_low);
   always #5 mclk = ~mclk;
   // Chip select straps sit at 101 except while the select scenario moves them
   secmd_engine #(.WRITE_CYCLES(64)) DUT (.mclk(mclk), .reset(reset), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .write_protect_input(wp),
      .chip_select_bit_two(cs[2]), .chip_select_bit_one(cs[1]), .chip_select_bit_zero(cs[0]),
      .write_busy(busy), .id_page_locked(locked));
   secmd_master M (.mclk(mclk), .scl(scl), .sda_low(m_low), .sda(sda));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task fl(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask : fl
   task results();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results
   task hdr(input logic [7:0] s, input logic [15:0] a);
      M.start();
      M.wbyte(s, ok);
      fl(ok, 1'b1);
      M.wbyte(a[15:8], ok);
      fl(ok, 1'b1);
      M.wbyte(a[7:0], ok);
      fl(ok, 1'b1);
   endtask : hdr
   // Write n bytes counting up from d; poll once during the cycle if accepted, then again 80 cycles later
   task wr(input logic [7:0] s, input logic [15:0] a, input int n, input logic [7:0] d,
      input logic e);
      hdr(s, a);
      for (int i = 0; i < n; i++) begin
         M.wbyte(d + 8'(i), ok);
         fl(ok, e);
      end
      M.stop();
      fl(busy, e);
      if (e) begin
         M.start();
         M.wbyte(s, ok);
         fl(ok, 1'b0);
      end
      repeat (80) @(posedge mclk);
      M.start();
      M.wbyte(s, ok);
      fl(ok, 1'b1);
      M.stop();
      fl(busy, 1'b0);
   endtask : wr
   // Random read of two bytes, the second refused, then a spare clock
   task rd(input logic [7:0] s, input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
      hdr(s, a);
      M.start();
      M.wbyte(s | 8'h01, ok);
      fl(ok, 1'b1);
      M.rbyte(1'b1, rb);
      chk(rb, e0);
      M.rbyte(1'b0, rb);
      chk(rb, e1);
      M.bit_io(1'b1, ok);
      fl(ok, 1'b1);
      M.stop();
   endtask : rd
   task t_byte();
      wr(8'hAA, 16'h0000, 1, 8'h11, 1'b1);
      M.start();
      M.wbyte(8'hAB, ok);
      fl(ok, 1'b1);
      M.rbyte(1'b0, rb);
      chk(rb, 8'hFF);
      M.stop();
      rd(8'hAA, 16'h0FFF, 8'hFF, 8'h11);
   endtask : t_byte
   task t_page();
      wr(8'hAA, 16'h003E, 3, 8'hA0, 1'b1);
      rd(8'hAA, 16'h003F, 8'hA1, 8'hFF);
      rd(8'hAA, 16'h001F, 8'hFF, 8'hA2);
   endtask : t_page
   task t_wp();
      @(posedge mclk) wp <= 1'b1;
      wr(8'hAA, 16'h003E, 1, 8'h55, 1'b0);
      rd(8'hAA, 16'h003E, 8'hA0, 8'hA1);
      @(posedge mclk) wp <= 1'b0;
   endtask : t_wp
   task t_abort();
      hdr(8'hAA, 16'h0100);
      M.stop();
      fl(busy, 1'b0);
      hdr(8'hAA, 16'h0100);
      M.wbyte(8'h77, ok);
      fl(ok, 1'b1);
      M.start();
      M.stop();
      fl(busy, 1'b0);
      rd(8'hAA, 16'h0100, 8'hFF, 8'hFF);
   endtask : t_abort
   // Wrong straps and wrong type are refused; moved straps make the same select answer
   task t_sel();
      M.start();
      M.wbyte(8'hA2, ok);
      fl(ok, 1'b0);
      M.start();
      M.wbyte(8'hCA, ok);
      fl(ok, 1'b0);
      M.stop();
      @(posedge mclk) cs <= 3'h1;
      M.start();
      M.wbyte(8'hA2, ok);
      fl(ok, 1'b1);
      M.stop();
      @(posedge mclk) cs <= 3'h5;
   endtask : t_sel
   task t_id();
      wr(8'hBA, 16'hFB05, 1, 8'h77, 1'b1);
      rd(8'hBA, 16'hFFE5, 8'h77, 8'hFF);
      hdr(8'hBA, 16'h0000);
      M.wbyte(8'h00, ok);
      fl(ok, 1'b1);
      M.start();
      M.stop();
      fl(busy, 1'b0);
      wr(8'hBA, 16'h0400, 1, 8'h02, 1'b1);
      fl(locked, 1'b1);
      wr(8'hBA, 16'h0006, 1, 8'h33, 1'b0);
   endtask : t_id
   // Main sequence
   initial begin
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      repeat (6) @(posedge mclk);
      t_byte();
      t_page();
      t_wp();
      t_abort();
      t_sel();
      t_id();
      results();
   end
   // Watchdog at 30000 cycles, about four times the expected run of 7500
   initial begin
      #300000;
      fail_count++;
      results();
   end
endmodule : secmd_engine_tb
